// *** logic/wec_pkg.sv ***
/*
 Constants, field positions and types shared by the wake-up event controller.
 Assumes a single 200 MHz core clock and an active-low asynchronous reset.
*/
// What this block does
// - In sleep or idle an external-pin change wakes the core only if its wake enable is set.
// - In sleep or idle a port 6 change wakes the core only if the pin-change wake enable is set.
// - In sleep or idle a finished conversion wakes the core only if its wake enable is set.
// - While a conversion wake-up is pending outside normal mode both clocks keep running.
// - Timebase and timer three events never wake from sleep but always wake from idle.
// - In green and normal mode each event vectors if its interrupt is enabled and interrupts are on, else continues.
// - After a wake-up the core vectors then continues if interrupts are on and the source's interrupt is enabled, else just continues.
// - The watchdog clear operation zeroes the watchdog count and its prescaler.
// - A reset-pin assertion or watchdog timeout resets the device in every mode.
// - With interrupts globally off before sleep, a wake-up resumes at the next instruction.
package wec_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned RST_HOLD_MS     = 18;
  localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MS * CLK_MHZ * 1000;
  localparam int unsigned RST_CNT_W       = 22;

  // ----------------------------------------------------------------------
  // Event sources and pins
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_SRC    = 6;
  localparam int unsigned SRC_EXT    = 0;
  localparam int unsigned SRC_PIN    = 1;
  localparam int unsigned SRC_TBASE  = 2;
  localparam int unsigned SRC_COMP   = 3;
  localparam int unsigned SRC_TIMER3 = 4;
  localparam int unsigned SRC_CONV   = 5;
  localparam int unsigned NUM_P6     = 6;
  localparam int unsigned SYNC_W     = 10;
  localparam int unsigned PIN_EXT    = 6;
  localparam int unsigned PIN_COMP   = 7;
  localparam int unsigned PIN_RSTB   = 8;
  localparam int unsigned PIN_LVD    = 9;
  localparam logic [9:0]  PIN_RST_VAL = 10'h100;

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  localparam int unsigned WDT_PRE_W = 8;
  localparam int unsigned WDT_CNT_W = 8;

  // ----------------------------------------------------------------------
  // Reset causes and types
  // ----------------------------------------------------------------------
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_PIN  = 2'h1;
  localparam logic [1:0] CAUSE_WDT  = 2'h2;
  localparam logic [1:0] CAUSE_LVD  = 2'h3;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_GREEN, MODE_IDLE, MODE_SLEEP} wec_mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_SLEEP, ST_RESET} wec_state_t;

endpackage : wec_pkg

// *** logic/wec_wakeup_ctrl.sv ***
/*
 Wake-up and interrupt event control across the four power modes.
 Assumes pins arrive asynchronously and peripheral pulses on the core clock.
*/
module wec_wakeup_ctrl #(
  parameter int unsigned RST_HOLD = wec_pkg::RST_HOLD_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire wec_pkg::wec_mode_t       powerMode,
  input  wire logic [wec_pkg::NUM_P6-1:0] port6Pin,
  input  wire logic                     extIntPin,
  input  wire logic                     compOutPin,
  input  wire logic                     resetPinB,
  input  wire logic                     lowVoltPin,
  input  wire logic                     timebaseOvf,
  input  wire logic                     timerThreeEvt,
  input  wire logic                     convDone,
  input  wire logic                     convBusy,
  input  wire logic                     extPinWakeEn,
  input  wire logic                     pinChangeWakeEn,
  input  wire logic                     convDoneWakeEn,
  input  wire logic                     compChangeWakeEn,
  input  wire logic [wec_pkg::NUM_SRC-1:0] srcIrqEn,
  input  wire logic                     globalIrqOnOp,
  input  wire logic                     globalIrqOffOp,
  input  wire logic                     sleepOp,
  input  wire logic                     watchdogClearOp,
  input  wire logic                     watchdogEn,
  output logic                          coreRun_r,
  output logic                          wakePulse_r,
  output logic                          vectorTake_r,
  output logic                          resumeNext_r,
  output logic [wec_pkg::NUM_SRC-1:0]   vectorSrc_r,
  output logic                          mainClockEn_r,
  output logic                          subClockEn_r,
  output logic                          deviceReset_r,
  output logic [1:0]                    resetCause_r,
  output logic                          globalIrqOn_r,
  output logic [wec_pkg::WDT_CNT_W-1:0] watchdogCount
);
  import wec_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic              rstMeta_r;
  logic              rstSync_r;
  logic [SYNC_W-1:0] pinsIn;
  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  assign pinsIn = {lowVoltPin, resetPinB, compOutPin, extIntPin, port6Pin};

  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
        syncA_r[i] <= PIN_RST_VAL[i];
        syncB_r[i] <= PIN_RST_VAL[i];
      end else begin
        syncA_r[i] <= pinsIn[i];
        syncB_r[i] <= syncA_r[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  wec_wdt_if wdtBus ();

  wec_watchdog u_wdt (
    .clk      (clk),
    .rstSyncB (rstSync_r),
    .wdtBus   (wdtBus)
  );

  assign watchdogCount = wdtBus.count;

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  logic [NUM_P6-1:0]  p6Prev_r;
  logic               extPrev_r;
  logic               compPrev_r;
  logic [NUM_SRC-1:0] evt;
  logic [NUM_SRC-1:0] wakeMask;
  logic [NUM_SRC-1:0] wakeGate;
  logic               resetReq;
  logic               asleep;

  wec_state_t         state_r, state_nxt;
  logic [RST_CNT_W-1:0] rstCnt_r, rstCnt_nxt;

  always_comb begin
    evt             = '0;
    evt[SRC_EXT]    = syncB_r[PIN_EXT] ^ extPrev_r;
    evt[SRC_PIN]    = |(syncB_r[NUM_P6-1:0] ^ p6Prev_r);
    evt[SRC_TBASE]  = timebaseOvf;
    evt[SRC_COMP]   = syncB_r[PIN_COMP] ^ compPrev_r;
    evt[SRC_TIMER3] = timerThreeEvt;
    evt[SRC_CONV]   = convDone;
    wakeMask             = '0;
    wakeMask[SRC_EXT]    = extPinWakeEn;
    wakeMask[SRC_PIN]    = pinChangeWakeEn;
    wakeMask[SRC_CONV]   = convDoneWakeEn;
    wakeMask[SRC_COMP]   = compChangeWakeEn;
    wakeMask[SRC_TBASE]  = (state_r == ST_IDLE);
    wakeMask[SRC_TIMER3] = (state_r == ST_IDLE);
  end

  assign wakeGate = evt & wakeMask;
  assign asleep   = (state_r == ST_SLEEP) || (state_r == ST_IDLE);
  assign resetReq = syncB_r[PIN_LVD] || !syncB_r[PIN_RSTB] || wdtBus.timeout;

  // ----------------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------------
  logic               coreRun_nxt, wake_nxt, vec_nxt, next_nxt, mainClk_nxt, subClk_nxt;
  logic               devRst_nxt, gIrq_nxt, keepClk;
  logic [NUM_SRC-1:0] vecSrc_nxt, pend;
  logic [1:0]         cause_nxt;

  always_comb begin
    state_nxt   = state_r;
    rstCnt_nxt  = rstCnt_r;
    coreRun_nxt = coreRun_r;
    devRst_nxt  = deviceReset_r;
    cause_nxt   = resetCause_r;
    wake_nxt    = 1'b0;
    vec_nxt     = 1'b0;
    next_nxt    = 1'b0;
    vecSrc_nxt  = '0;
    pend        = '0;
    gIrq_nxt    = globalIrqOn_r;
    if (globalIrqOffOp) gIrq_nxt = 1'b0;
    if (globalIrqOnOp) gIrq_nxt = 1'b1;
    if (resetReq) begin
      state_nxt   = ST_RESET;
      rstCnt_nxt  = '0;
      coreRun_nxt = 1'b0;
      devRst_nxt  = 1'b1;
      gIrq_nxt    = 1'b0;
      if (syncB_r[PIN_LVD]) cause_nxt = CAUSE_LVD;
      else if (!syncB_r[PIN_RSTB]) cause_nxt = CAUSE_PIN;
      else cause_nxt = CAUSE_WDT;
    end else begin
      case (state_r)
        ST_RESET: begin
          rstCnt_nxt = rstCnt_r + 1'b1;
          if (rstCnt_r == RST_CNT_W'(RST_HOLD - 1)) begin
            state_nxt   = ST_RUN;
            coreRun_nxt = 1'b1;
            devRst_nxt  = 1'b0;
          end
        end
        ST_RUN: begin
          if (|evt) begin
            pend = evt & srcIrqEn;
            if (globalIrqOn_r && (|pend)) begin
              vec_nxt    = 1'b1;
              vecSrc_nxt = pend;
            end else begin
              next_nxt = 1'b1;
            end
          end
          if (sleepOp) begin
            state_nxt   = (powerMode == MODE_IDLE) ? ST_IDLE : ST_SLEEP;
            coreRun_nxt = 1'b0;
          end
        end
        ST_IDLE, ST_SLEEP: begin
          if (|wakeGate) begin
            state_nxt   = ST_RUN;
            coreRun_nxt = 1'b1;
            wake_nxt    = 1'b1;
            pend        = wakeGate & srcIrqEn;
            if (globalIrqOn_r && (|pend)) begin
              vec_nxt    = 1'b1;
              vecSrc_nxt = pend;
            end else begin
              next_nxt = 1'b1;
            end
          end
        end
        default: begin
          state_nxt = ST_RESET;
        end
      endcase
    end
    keepClk     = convBusy && convDoneWakeEn && (powerMode != MODE_NORMAL);
    mainClk_nxt = keepClk || (state_nxt == ST_RESET)
                  || ((state_nxt == ST_RUN) && (powerMode == MODE_NORMAL));
    subClk_nxt  = keepClk || (state_nxt != ST_SLEEP);
  end

  assign wdtBus.clearOp = watchdogClearOp || (state_r == ST_RESET)
                          || ((state_r == ST_RUN) && sleepOp);
  assign wdtBus.enable  = watchdogEn;

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r       <= ST_RESET;
      rstCnt_r      <= '0;
      coreRun_r     <= 1'b0;
      wakePulse_r   <= 1'b0;
      vectorTake_r  <= 1'b0;
      resumeNext_r  <= 1'b0;
      vectorSrc_r   <= '0;
      mainClockEn_r <= 1'b1;
      subClockEn_r  <= 1'b1;
      deviceReset_r <= 1'b1;
      resetCause_r  <= CAUSE_NONE;
      globalIrqOn_r <= 1'b0;
      p6Prev_r      <= '0;
      extPrev_r     <= 1'b0;
      compPrev_r    <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      rstCnt_r      <= rstCnt_nxt;
      coreRun_r     <= coreRun_nxt;
      wakePulse_r   <= wake_nxt;
      vectorTake_r  <= vec_nxt;
      resumeNext_r  <= next_nxt;
      vectorSrc_r   <= vecSrc_nxt;
      mainClockEn_r <= mainClk_nxt;
      subClockEn_r  <= subClk_nxt;
      deviceReset_r <= devRst_nxt;
      resetCause_r  <= cause_nxt;
      globalIrqOn_r <= gIrq_nxt;
      p6Prev_r      <= syncB_r[NUM_P6-1:0];
      extPrev_r     <= syncB_r[PIN_EXT];
      compPrev_r    <= syncB_r[PIN_COMP];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_ext_pin_wake: assert property (@(posedge clk) disable iff (!rstSync_r)
    (asleep && !resetReq && evt[SRC_EXT] && extPinWakeEn) |=> wakePulse_r && coreRun_r)
    else $error("external pin event did not wake");

  a_pin_change_wake: assert property (@(posedge clk) disable iff (!rstSync_r)
    (asleep && !resetReq && !(|(evt & wakeMask & ~(NUM_SRC'(1) << SRC_PIN)))
     && evt[SRC_PIN] && !pinChangeWakeEn) |=> !coreRun_r && !wakePulse_r)
    else $error("port change woke without enable");

  a_conv_done_wake: assert property (@(posedge clk) disable iff (!rstSync_r)
    (asleep && !resetReq && evt[SRC_CONV] && convDoneWakeEn) |=> wakePulse_r ##1 !wakePulse_r)
    else $error("conversion event did not wake");

  a_conv_clock_keep: assert property (@(posedge clk) disable iff (!rstSync_r)
    (convBusy && convDoneWakeEn && (powerMode != MODE_NORMAL)) |=> mainClockEn_r && subClockEn_r)
    else $error("clocks stopped during pending conversion");

  a_timer_sleep_hold: assert property (@(posedge clk) disable iff (!rstSync_r)
    (state_r == ST_SLEEP && !resetReq
     && ((evt & ~((NUM_SRC'(1) << SRC_TBASE) | (NUM_SRC'(1) << SRC_TIMER3))) == '0))
    |=> state_r == ST_SLEEP)
    else $error("timer event left sleep");

  a_run_event_action: assert property (@(posedge clk) disable iff (!rstSync_r)
    (state_r == ST_RUN && !resetReq && (|evt)) |=> (vectorTake_r ^ resumeNext_r) && !wakePulse_r)
    else $error("run event not handled exactly once");

  a_wake_resume: assert property (@(posedge clk) disable iff (!rstSync_r)
    wakePulse_r |-> (vectorTake_r ^ resumeNext_r)
      && (vectorTake_r == ($past(globalIrqOn_r) && (|$past(wakeGate & srcIrqEn))))
      && (vectorSrc_r == (vectorTake_r ? $past(wakeGate & srcIrqEn) : '0)))
    else $error("wake-up without resume action");

  a_irq_off_next: assert property (@(posedge clk) disable iff (!rstSync_r)
    (asleep && !resetReq && (|wakeGate) && !globalIrqOn_r) |=> resumeNext_r && !vectorTake_r)
    else $error("vectored with interrupts off");

  a_reset_pin_wdt: assert property (@(posedge clk) disable iff (!rstSync_r)
    (!syncB_r[PIN_RSTB] || wdtBus.timeout) |=> deviceReset_r && !coreRun_r && state_r == ST_RESET)
    else $error("reset source did not reset device");

  a_low_volt_reset: assert property (@(posedge clk) disable iff (!rstSync_r)
    syncB_r[PIN_LVD] |=> deviceReset_r && (resetCause_r == CAUSE_LVD))
    else $error("low voltage did not force reset");

endmodule : wec_wakeup_ctrl

// *** logic/wec_watchdog.sv ***
/*
 Watchdog counter with prescaler and a one-cycle timeout pulse.
 Assumes a synchronised reset and a same-clock clear request.
*/
module wec_watchdog (
  input  wire logic clk,
  input  wire logic rstSyncB,
  wec_wdt_if.wdt    wdtBus
);
  import wec_pkg::*;

  logic [WDT_PRE_W-1:0] pre_r, pre_nxt;
  logic [WDT_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                 tmo_r, tmo_nxt;

  always_comb begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    tmo_nxt = 1'b0;
    if (wdtBus.clearOp) begin
      pre_nxt = '0;
      cnt_nxt = '0;
    end else if (wdtBus.enable) begin
      pre_nxt = pre_r + 1'b1;
      if (&pre_r) begin
        cnt_nxt = cnt_r + 1'b1;
        tmo_nxt = &cnt_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      pre_r <= '0;
      cnt_r <= '0;
      tmo_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  assign wdtBus.count   = cnt_r;
  assign wdtBus.timeout = tmo_r;

  a_wdt_clear_zero: assert property (@(posedge clk) disable iff (!rstSyncB)
    wdtBus.clearOp |=> (cnt_r == '0) && (pre_r == '0) && !tmo_r)
    else $error("watchdog not zeroed by clear");

endmodule : wec_watchdog

// *** logic/wec_wdt_if.sv ***
/*
 Interface between the wake-up controller and its watchdog counter.
 Assumes both ends run on the same clock.
*/
interface wec_wdt_if;
  import wec_pkg::*;
  logic                 clearOp;
  logic                 enable;
  logic                 timeout;
  logic [WDT_CNT_W-1:0] count;
  modport ctrl (output clearOp, output enable, input timeout, input count);
  modport wdt  (input clearOp, input enable, output timeout, output count);
endinterface : wec_wdt_if

// *** tb/wec_event_src.sv ***
/*
 Behavioural model of the pins and peripherals that raise events toward the wake-up controller.
 Assumes the bench calls its tasks between clock edges and drives nothing of these signals itself.
*/
module wec_event_src (
  input  wire logic        clk,
  output logic [5:0]       port6Pin,
  output logic             extIntPin,
  output logic             compOutPin,
  output logic             resetPinB,
  output logic             lowVoltPin,
  output logic             timebaseOvf,
  output logic             timerThreeEvt,
  output logic             convDone,
  output logic             convBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  import wec_pkg::*;

  // ----------------------------------------------------------------------
  // Pins change levels, peripherals give one-cycle pulses on the falling edge
  // ----------------------------------------------------------------------
  initial begin
    port6Pin      = 6'h15;
    extIntPin     = 1'b0;
    compOutPin    = 1'b0;  // Comparator output already routed to its pin
    resetPinB     = 1'b1;
    lowVoltPin    = 1'b0;
    timebaseOvf   = 1'b0;
    timerThreeEvt = 1'b0;
    convDone      = 1'b0;
    convBusy      = 1'b0;
  end

  task automatic fire(input int src);
    @(negedge clk);
    case (src)
      SRC_EXT:    extIntPin = ~extIntPin;
      SRC_PIN:    port6Pin[2] = ~port6Pin[2];
      SRC_COMP:   compOutPin = ~compOutPin;
      SRC_TBASE:  timebaseOvf = 1'b1;
      SRC_TIMER3: timerThreeEvt = 1'b1;
      default:    convDone = 1'b1;
    endcase
    @(negedge clk);
    timebaseOvf   = 1'b0;
    timerThreeEvt = 1'b0;
    convDone      = 1'b0;
  endtask : fire

  task automatic set_rst(input logic pinB, input logic lvd);
    @(negedge clk);
    resetPinB  = pinB;
    lowVoltPin = lvd;
  endtask : set_rst

  task automatic busy(input logic b);
    @(negedge clk);
    convBusy = b;
  endtask : busy
endmodule : wec_event_src

// *** tb/wec_wakeup_ctrl_tb.sv ***
/*
 Self-checking bench for the wake-up controller, with the event model on its far side.
 Assumes a shortened device reset hold and events spaced by the response window.
*/
module wec_wakeup_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wec_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam int HOLD = 8;
  localparam int LIMIT = 90000;
  logic clk = 1'b0, rst_b = 1'b0, sleepOp = 1'b0, watchdogEn = 1'b0, watchdogClearOp = 1'b0;
  logic globalIrqOnOp = 1'b0, globalIrqOffOp = 1'b0, convBusy, extIntPin, compOutPin;
  logic resetPinB, lowVoltPin, timebaseOvf, timerThreeEvt, convDone;
  logic coreRun_r, wakePulse_r, vectorTake_r, resumeNext_r, mainClockEn_r, subClockEn_r;
  logic deviceReset_r, globalIrqOn_r;
  logic [1:0] resetCause_r;
  logic [3:0] wakeEn = 4'h0;
  logic [5:0] port6Pin, vectorSrc_r, srcIrqEn = 6'h3f;
  logic [7:0] watchdogCount, fl, sv;
  wec_mode_t powerMode = MODE_NORMAL;
  wec_mode_t low[2] = '{MODE_SLEEP, MODE_IDLE};
  wec_mode_t run[2] = '{MODE_NORMAL, MODE_GREEN};
  int failures = 0, num_checks = 0, cycles = 0;
  logic gated, wakes;

  always #2.5 clk = ~clk;

  wec_event_src u_wec_event_src (.clk(clk), .port6Pin(port6Pin), .extIntPin(extIntPin),
    .compOutPin(compOutPin), .resetPinB(resetPinB), .lowVoltPin(lowVoltPin),
    .timebaseOvf(timebaseOvf), .timerThreeEvt(timerThreeEvt), .convDone(convDone),
    .convBusy(convBusy));

  wec_wakeup_ctrl #(.RST_HOLD(HOLD)) u_wec_wakeup_ctrl (.clk(clk), .rst_b(rst_b),
    .powerMode(powerMode), .port6Pin(port6Pin), .extIntPin(extIntPin), .compOutPin(compOutPin),
    .resetPinB(resetPinB), .lowVoltPin(lowVoltPin), .timebaseOvf(timebaseOvf),
    .timerThreeEvt(timerThreeEvt), .convDone(convDone), .convBusy(convBusy),
    .extPinWakeEn(wakeEn[0]), .pinChangeWakeEn(wakeEn[1]), .convDoneWakeEn(wakeEn[2]),
    .compChangeWakeEn(wakeEn[3]), .srcIrqEn(srcIrqEn), .globalIrqOnOp(globalIrqOnOp),
    .globalIrqOffOp(globalIrqOffOp), .sleepOp(sleepOp), .watchdogClearOp(watchdogClearOp),
    .watchdogEn(watchdogEn), .coreRun_r(coreRun_r), .wakePulse_r(wakePulse_r),
    .vectorTake_r(vectorTake_r), .resumeNext_r(resumeNext_r), .vectorSrc_r(vectorSrc_r),
    .mainClockEn_r(mainClockEn_r), .subClockEn_r(subClockEn_r),
    .deviceReset_r(deviceReset_r), .resetCause_r(resetCause_r),
    .globalIrqOn_r(globalIrqOn_r), .watchdogCount(watchdogCount));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Captures the first answer within eight cycles as {wake, vector, resume} and its sources.
  task automatic wait_resp();
    fl = 8'h0;
    sv = 8'h0;
    repeat (8) begin
      if (fl == 8'h0 && (vectorTake_r === 1'b1 || resumeNext_r === 1'b1)) begin
        fl = {5'h0, wakePulse_r, vectorTake_r, resumeNext_r};
        sv = {2'h0, vectorSrc_r};
      end
      @(negedge clk);
    end
  endtask : wait_resp

  task automatic wait_rst(input int n);
    for (int i = 0; i < n && deviceReset_r !== 1'b1; i++) @(posedge clk);
  endtask : wait_rst

  task automatic wait_run(input int n);
    for (int i = 0; i < n && coreRun_r !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
  endtask : wait_run

  task automatic go_sleep(input wec_mode_t m);
    @(negedge clk);
    powerMode = m;
    sleepOp   = 1'b1;
    @(negedge clk);
    sleepOp = 1'b0;
    repeat (2) @(negedge clk);
  endtask : go_sleep

  task automatic pulse_op(input int which);
    @(negedge clk);
    if (which == 0) globalIrqOnOp = 1'b1;
    else if (which == 1) globalIrqOffOp = 1'b1;
    else watchdogClearOp = 1'b1;
    @(negedge clk);
    globalIrqOnOp   = 1'b0;
    globalIrqOffOp  = 1'b0;
    watchdogClearOp = 1'b0;
  endtask : pulse_op

  // Watchdog off and enables set before sleep is the last step
  task automatic event_case(input wec_mode_t m, input int src, input logic g,
                            input logic [2:0] expFl, input logic [7:0] expSv);
    @(negedge clk);
    wakeEn = g ? 4'hf : 4'h0;
    if (m == MODE_SLEEP || m == MODE_IDLE) go_sleep(m);
    else powerMode = m;
    u_wec_event_src.fire(src);
    wait_resp();
    chk("response flags", {5'h0, expFl}, fl);
    chk("vector sources", expSv, sv);
    if (fl == 8'h0) begin
      chk("core stays stopped", 8'h0, {7'h0, coreRun_r});
      wakeEn = 4'hf;
      u_wec_event_src.fire(SRC_EXT);
      wait_resp();
    end
  endtask : event_case

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    chk("reset held", 8'h1, {7'h0, deviceReset_r});
    chk("clocks in reset", 8'h3, {6'h0, mainClockEn_r, subClockEn_r});
    rst_b = 1'b1;
    wait_run(40);
    chk("run after reset", 8'h1, {7'h0, coreRun_r});
    chk("irq off after reset", 8'h0, {7'h0, globalIrqOn_r});
    chk("cause after power-on", {6'h0, CAUSE_NONE}, {6'h0, resetCause_r});
    pulse_op(0);
    for (int mi = 0; mi < 2; mi++) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        for (int g = 0; g < 2; g++) begin
          gated = (s != SRC_TBASE && s != SRC_TIMER3);
          wakes = gated ? g[0] : (low[mi] == MODE_IDLE);
          event_case(low[mi], s, g[0], {wakes, wakes, 1'b0}, 8'(wakes) << s);
        end
        event_case(run[mi], s, 1'b0, 3'h2, 8'h1 << s);
      end
    end
    @(negedge clk) srcIrqEn = 6'h1f;
    event_case(MODE_SLEEP, SRC_CONV, 1'b1, 3'h5, 8'h0);
    event_case(MODE_GREEN, SRC_CONV, 1'b0, 3'h1, 8'h0);
    srcIrqEn = 6'h3f;
    pulse_op(1);
    for (int s = 0; s < NUM_SRC; s++) event_case(MODE_NORMAL, s, 1'b0, 3'h1, 8'h0);
    event_case(MODE_SLEEP, SRC_PIN, 1'b1, 3'h5, 8'h0);
    event_case(MODE_IDLE, SRC_COMP, 1'b1, 3'h5, 8'h0);
    pulse_op(0);
    wakeEn = 4'hf;
    u_wec_event_src.busy(1'b1);
    go_sleep(MODE_SLEEP);
    chk("clocks kept in sleep", 8'h3, {6'h0, mainClockEn_r, subClockEn_r});
    u_wec_event_src.busy(1'b0);
    repeat (2) @(negedge clk);
    chk("clocks stop in sleep", 8'h0, {6'h0, mainClockEn_r, subClockEn_r});
    u_wec_event_src.fire(SRC_CONV);
    wait_resp();
    chk("conversion wake", 8'h6, fl);
    powerMode = MODE_GREEN;
    u_wec_event_src.busy(1'b1);
    repeat (2) @(negedge clk);
    chk("clocks kept in green", 8'h3, {6'h0, mainClockEn_r, subClockEn_r});
    u_wec_event_src.busy(1'b0);
    repeat (2) @(negedge clk);
    chk("green clocks", 8'h1, {6'h0, mainClockEn_r, subClockEn_r});
    watchdogEn = 1'b1;
    repeat (600) @(negedge clk);
    chk("watchdog count", 8'h2, watchdogCount);
    pulse_op(2);
    chk("watchdog cleared", 8'h0, watchdogCount);
    repeat (300) @(negedge clk);
    chk("watchdog restart", 8'h1, watchdogCount);
    wakeEn = 4'h0;
    go_sleep(MODE_SLEEP);
    wait_rst(66000);
    @(negedge clk) watchdogEn = 1'b0;
    chk("watchdog cause", {6'h0, CAUSE_WDT}, {6'h0, resetCause_r});
    wait_run(40);
    pulse_op(0);
    u_wec_event_src.set_rst(1'b0, 1'b0);
    wait_rst(10);
    #1;
    chk("pin cause", {6'h0, CAUSE_PIN}, {6'h0, resetCause_r});
    chk("stopped in reset", 8'h0, {7'h0, coreRun_r});
    u_wec_event_src.set_rst(1'b1, 1'b0);
    wait_run(40);
    chk("irq cleared by reset", 8'h0, {7'h0, globalIrqOn_r});
    wakeEn = 4'hf;
    go_sleep(MODE_SLEEP);
    u_wec_event_src.set_rst(1'b1, 1'b1);
    wait_rst(10);
    #1;
    chk("low voltage cause", {6'h0, CAUSE_LVD}, {6'h0, resetCause_r});
    u_wec_event_src.set_rst(1'b1, 1'b0);
    wait_run(40);
    chk("run after low voltage", 8'h1, {7'h0, coreRun_r});
    test_done();
  end
endmodule : wec_wakeup_ctrl_tb
